// ---- rtl/sac_params.svh ----
// Purpose: timing, field and reset constants of the converter control
// Assumes: ref_clk at 20 MHz
// Notes: definitions only
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH

`define SAC_WIDTH 8
`define SAC_CLK_NS 50
// half period of the converter clock, also the least msb settling time
`define SAC_HALF_NS 550
`define SAC_HALF_CYC ((`SAC_HALF_NS + `SAC_CLK_NS - 1) / `SAC_CLK_NS)
`define SAC_CNT_W 8
`define SAC_CODE_MSB 8'h80
`define SAC_CODE_LSB 8'h01
`define SAC_CODE_CLEAR 8'h00
`define SAC_CNT_ZERO 8'h00
`define SAC_PINS_IDLE 4'hB

`endif

// ---- rtl/sac_pkg.sv ----
// Purpose: types shared by the converter control
// Assumes: nothing
// Notes: constants live in sac_params.svh
package sac_pkg;

  typedef enum logic [1:0] {
    SAC_IDLE = 2'b00,
    SAC_HOLD = 2'b01,
    SAC_WAIT_RISE = 2'b10,
    SAC_RUN = 2'b11
  } sac_state_t;

  // asynchronous pins, carried together through the synchroniser
  typedef struct packed {
    logic convert_b;
    logic cmp_above;
    logic read_b;
    logic busy_line;
  } sac_pins_t;

endpackage

// ---- rtl/sac_conv.sv ----
// Purpose: successive-approximation sequencer of an 8-bit converter
// Assumes: convert_b, read_b, cmp_above and busy_line_i are asynchronous pins
// Notes: converter clock is made here from ref_clk; decisions on its falling edge
// Operation
// - convert low: busy low, code msb only
// - falling edge resolves bit on trial
// - same edge sets next lower trial bit
// - eight decisions, then busy released high
// - busy rises with the lsb decision
// - async strobe, result 7.5-8.5 periods later
// - strobe low holds cleared msb-only state
// - wait rising then falling edge before msb
// - strobe low anytime aborts and restarts
// - read high tristate, low drives code
// - reads never change the code
// - enabled outputs show result at busy rise
// - free-running conversion every eighth clock
// - busy is open-drain, wire-and capable
// - code drives the ladder dac directly
`timescale 1ns/1ps
`include "sac_params.svh"

module sac_conv #(
  parameter int WIDTH = `SAC_WIDTH,
  parameter int HALF_CYC = `SAC_HALF_CYC
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic convert_b,
  input wire logic read_b,
  input wire logic cmp_above,
  input wire logic busy_line_i,
  output logic busy_o,
  output logic busy_oe,
  output logic line_free,
  output logic [WIDTH-1:0] dac_code,
  output logic [WIDTH-1:0] data_o,
  output logic [WIDTH-1:0] data_oe
);

  // ************************************************************
  // pin synchroniser
  // ************************************************************
  sac_pkg::sac_pins_t pins_raw;
  sac_pkg::sac_pins_t sync_a;
  sac_pkg::sac_pins_t sync_b;

  assign pins_raw.convert_b = convert_b;
  assign pins_raw.cmp_above = cmp_above;
  assign pins_raw.read_b = read_b;
  assign pins_raw.busy_line = busy_line_i;

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_a <= `SAC_PINS_IDLE;
      sync_b <= `SAC_PINS_IDLE;
    end else begin
      sync_a <= pins_raw;
      sync_b <= sync_a;
    end
  end

  // ************************************************************
  // converter clock divider
  // ************************************************************
  // a fixed half period of 550 ns keeps the converter clock below its
  // maximum and gives the msb its settling time on every first decision
  logic [`SAC_CNT_W-1:0] div_cnt;
  logic [`SAC_CNT_W-1:0] next_div_cnt;
  logic conv_phase;
  logic next_conv_phase;
  logic wrap;
  logic rise_evt;
  logic fall_evt;

  assign wrap = (div_cnt == `SAC_CNT_W'(HALF_CYC - 1));
  assign rise_evt = wrap && !conv_phase;
  assign fall_evt = wrap && conv_phase;

  always_comb begin
    next_div_cnt = div_cnt + `SAC_CNT_W'(1);
    next_conv_phase = conv_phase;
    if (wrap) begin
      next_div_cnt = `SAC_CNT_ZERO;
      next_conv_phase = !conv_phase;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_cnt <= `SAC_CNT_ZERO;
      conv_phase <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      conv_phase <= next_conv_phase;
    end
  end

  // ************************************************************
  // approximation sequencer
  // ************************************************************
  sac_pkg::sac_state_t state;
  sac_pkg::sac_state_t next_state;
  logic [WIDTH-1:0] code;
  logic [WIDTH-1:0] next_code;
  logic [WIDTH-1:0] trial;
  logic [WIDTH-1:0] next_trial;
  logic [WIDTH-1:0] lower;

  assign lower = trial >> 1;

  // per-bit decision: the bit on trial keeps or drops its 1, the next lower
  // bit becomes the new trial, every other bit holds its value
  logic [WIDTH-1:0] decided;

  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      assign decided[gi] = lower[gi] | (trial[gi] ? !sync_b.cmp_above : code[gi]);
    end
  endgenerate

  always_comb begin
    next_state = state;
    next_code = code;
    next_trial = trial;
    if (!sync_b.convert_b) begin
      // strobe is never locked out; low at any time restarts
      next_state = sac_pkg::SAC_HOLD;
      next_code = `SAC_CODE_MSB;
      next_trial = `SAC_CODE_MSB;
    end else begin
      case (state)
        sac_pkg::SAC_IDLE: begin
          next_state = sac_pkg::SAC_IDLE;
        end
        sac_pkg::SAC_HOLD: begin
          next_state = sac_pkg::SAC_WAIT_RISE;
        end
        sac_pkg::SAC_WAIT_RISE: begin
          // a rising then a falling edge: at least half a period of settling
          if (rise_evt) begin
            next_state = sac_pkg::SAC_RUN;
          end
        end
        sac_pkg::SAC_RUN: begin
          if (fall_evt) begin
            next_code = decided;
            next_trial = lower;
            if (trial == `SAC_CODE_LSB) begin
              next_state = sac_pkg::SAC_IDLE;
            end
          end
        end
        default: begin
          next_state = sac_pkg::SAC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= sac_pkg::SAC_IDLE;
      code <= `SAC_CODE_CLEAR;
      trial <= `SAC_CODE_CLEAR;
    end else begin
      state <= next_state;
      code <= next_code;
      trial <= next_trial;
    end
  end

  // ************************************************************
  // busy and data outputs
  // ************************************************************
  logic busy_drive;
  logic next_busy_drive;
  logic read_en;
  logic next_read_en;

  // busy leaves with the same edge that stores the lsb, so data is valid
  always_comb begin
    next_busy_drive = (next_state != sac_pkg::SAC_IDLE);
    next_read_en = !sync_b.read_b;
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      busy_drive <= 1'b0;
      read_en <= 1'b0;
    end else begin
      busy_drive <= next_busy_drive;
      read_en <= next_read_en;
    end
  end

  // open drain: only ever pulls low, the pull-up is outside
  assign busy_o = 1'b0;
  assign busy_oe = busy_drive;
  assign line_free = sync_b.busy_line;
  assign dac_code = code;
  // reads only gate the drivers, the code is untouched
  assign data_o = code;
  genvar go;
  generate
    for (go = 0; go < WIDTH; go++) begin : g_oe
      assign data_oe[go] = read_en;
    end
  endgenerate

endmodule // sac_conv

// ---- tb/sac_conv_asserts.sv ----
// Purpose: port checks of the converter control
// Assumes: parameters match the bound instance
// Notes: bound below
`timescale 1ns/1ps
module sac_conv_asserts #(
  parameter int WIDTH = 8,
  parameter int HALF_CYC = 11
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic convert_b,
  input wire logic read_b,
  input wire logic busy_line_i,
  input wire logic busy_o,
  input wire logic busy_oe,
  input wire logic line_free,
  input wire logic [WIDTH-1:0] dac_code,
  input wire logic [WIDTH-1:0] data_oe
);
  // margins cover the synchroniser latency
  localparam int EARLY = 15 * HALF_CYC - 2;
  localparam int LATE = 17 * HALF_CYC + 8;
  // cycles spent busy since the strobe was last released; an abort resets it
  logic [15:0] run_len;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      run_len <= 16'h0000;
    end else if (!convert_b || !busy_oe) begin
      run_len <= 16'h0000;
    end else if (run_len != 16'hFFFF) begin
      run_len <= run_len + 16'h0001;
    end
  end
  default clocking @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  a_busy_drive: assert property (busy_o == 1'b0) else $error("busy drive not low");
  a_line_seen: assert property (busy_line_i[*3] |=> line_free) else $error("line lost");
  a_read_off: assert property (read_b[*4] |=> data_oe == '0) else $error("bus driven");
  a_read_on: assert property ((!read_b)[*4] |=> data_oe == '1) else $error("bus idle");
  a_hold_msb: assert property ((!convert_b)[*4] |=> busy_oe && dac_code == 8'h80)
    else $error("strobe hold wrong");
  a_idle_code: assert property ((convert_b && !busy_oe)[*4] |=> $stable(dac_code))
    else $error("idle code moved");
  a_not_early: assert property ($rose(convert_b) |-> ##EARLY busy_oe)
    else $error("finished early");
  a_done_late: assert property (run_len <= 16'(LATE))
    else $error("finished late");
endmodule // sac_conv_asserts

bind sac_conv sac_conv_asserts #(.WIDTH(WIDTH), .HALF_CYC(HALF_CYC)) chk (.ref_clk, .rst_b,
  .convert_b, .read_b, .busy_line_i, .busy_o, .busy_oe, .line_free, .dac_code, .data_oe);

// ---- tb/sac_far_end.sv ----
// Purpose: comparator and start glue beside the converter control
// Assumes: vin is the input level as a code
// Notes: busy line has a pull-up
`timescale 1ns/1ps
module sac_far_end (
  input wire logic [7:0] vin,
  input wire logic [7:0] dac_code,
  input wire logic busy_o,
  input wire logic busy_oe,
  input wire logic start_b,
  input wire logic free_run,
  output logic cmp_above,
  output logic busy_line,
  output logic convert_b
);
  assign cmp_above = dac_code > vin;
  assign busy_line = busy_oe ? busy_o : 1'b1;
  // nor of start pulse and busy, restart as soon as busy is released
  assign convert_b = start_b & ~(free_run & busy_line);
endmodule // sac_far_end

// ---- tb/sar_adc_conversion_control_bench.sv ----
// Purpose: self-checking bench of the converter control
// Assumes: HALF_CYC shortened to 4
// Notes: inputs change 1 ns after the rising edge
`timescale 1ns/1ps
module sar_adc_conversion_control_bench;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start_b = 1'b1;
  logic read_b = 1'b1;
  logic free_run = 1'b0;
  logic [7:0] vin = 8'h00;
  logic convert_b, cmp_above, busy_line, busy_o, busy_oe, line_free;
  logic [7:0] dac_code, data_o, data_oe;
  int mismatches = 0;
  int checks_done = 0;
  int falls;
  always #25 ref_clk = ~ref_clk;
  sac_conv #(.HALF_CYC(4)) uut (.ref_clk(ref_clk), .rst_b(rst_b), .convert_b(convert_b),
    .read_b(read_b), .cmp_above(cmp_above), .busy_line_i(busy_line), .busy_o(busy_o),
    .busy_oe(busy_oe), .line_free(line_free), .dac_code(dac_code), .data_o(data_o),
    .data_oe(data_oe));
  sac_far_end far (.vin(vin), .dac_code(dac_code), .busy_o(busy_o), .busy_oe(busy_oe),
    .start_b(start_b), .free_run(free_run), .cmp_above(cmp_above), .busy_line(busy_line),
    .convert_b(convert_b));
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic give_verdict;
    $display("mismatches %0d checks_done %0d", mismatches, checks_done);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic cmp8(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic conv(input logic [7:0] v);
    vin = v;
    start_b = 1'b0;
    tick(4);
    start_b = 1'b1;
    cmp8("busy", 8'h01, {7'h00, busy_oe});
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    while (busy_oe !== 1'b0 && n < 200) begin
      tick(1);
      n++;
    end
    if (n == 200) begin
      cmp8("busy wait", 8'h00, 8'h01);
      give_verdict();
    end
  endtask
  task automatic read_chk(input logic [7:0] exp);
    read_b = 1'b0;
    tick(4);
    cmp8("enable", 8'hFF, data_oe);
    cmp8("data", exp, data_o);
    read_b = 1'b1;
    tick(4);
    cmp8("enable", 8'h00, data_oe);
  endtask
  task automatic t_values;
    logic [7:0] v[6] = '{8'h00, 8'hFF, 8'hA5, 8'h5A, 8'h80, 8'h7F};
    foreach (v[i]) begin
      conv(v[i]);
      wait_idle();
      read_chk(v[i]);
      read_chk(v[i]);
    end
  endtask
  task automatic t_abort;
    conv(8'h33);
    tick(20);
    conv(8'hC4);
    wait_idle();
    read_chk(8'hC4);
  endtask
  task automatic t_live;
    read_b = 1'b0;
    conv(8'h6B);
    wait_idle();
    tick(2);
    cmp8("live data", 8'h6B, data_o);
    read_b = 1'b1;
  endtask
  task automatic t_free;
    logic prev;
    conv(8'h96);
    free_run = 1'b1;
    wait_idle();
    falls = 0;
    prev = busy_oe;
    repeat (320) begin
      tick(1);
      if (busy_oe === 1'b0 && prev === 1'b1) falls++;
      prev = busy_oe;
    end
    free_run = 1'b0;
    cmp8("free runs", 8'h04, falls[7:0]);
    wait_idle();
    read_chk(8'h96);
  endtask
  initial begin
    tick(6);
    rst_b = 1'b1;
    tick(1);
    cmp8("reset code", 8'h00, dac_code);
    cmp8("reset busy", 8'h00, {7'h00, busy_oe});
    t_values();
    t_abort();
    t_live();
    t_free();
    give_verdict();
  end
endmodule // sar_adc_conversion_control_bench
